// >>> inc/memmap_pkg.sv
package memmap_pkg;
  // Register indices (printed offsets; byte address is index on this plain port)
  localparam logic [7:0] ADDR_PORT4_CTRL = 8'h92;
  localparam logic [7:0] ADDR_MEM_CTRL = 8'hc6;
  localparam logic [7:0] ADDR_ADDR_CTRL = 8'h9d;
  localparam logic [7:0] ADDR_CLK_CTRL = 8'h8e;
  localparam logic [7:0] ADDR_CLK_MODE = 8'hc4;
  localparam logic [7:0] ADDR_STATUS = 8'hc7;
  // Field positions
  localparam int UPPER_LSB = 3;
  localparam int CE_LSB = 0;
  localparam int IDM_LSB = 6;
  localparam int CAN_SEL_BIT = 5;
  localparam int STACK_BIT = 2;
  localparam int MULT_BIT = 2;
  localparam int CLKDIV_LSB = 0;
  // Reset values
  localparam logic [7:0] PORT4_RESET = 8'h3f;
  localparam logic [7:0] MEM_RESET = 8'h00;
  localparam logic [2:0] STRETCH_RESET = 3'h1;
  localparam logic [1:0] CLKDIV_RESET = 2'h2;
  // Memory windows (24-bit addresses)
  localparam logic [23:0] SRAM_LOW_BASE = 24'h000000;
  localparam logic [23:0] SRAM_MID_BASE = 24'h00f000;
  localparam logic [23:0] SRAM_HIGH_BASE = 24'h400000;
  localparam logic [23:0] CAN_LOW_BASE = 24'h00ee00;
  localparam logic [23:0] CAN_HIGH_BASE = 24'h401000;
  localparam int SRAM_BITS = 12;
  localparam int CAN_BITS = 9;
  localparam int STACK_BITS = 10;
  // Machine cycle length minus one in system clocks for divide-by-4 (the module uses 4)
  localparam logic [1:0] CLKS_PER_MC_DIV4 = 2'h3;
  localparam logic [3:0] MC_INTERNAL = 4'h2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_STROBE = 4'b0100,
    ST_HOLD = 4'b1000
  } bus_state_t;
endpackage

// >>> core/memmap_stretch.sv
// How it works
// - Place SRAM and CAN area by config
// - Stack mode reserves lowest 1kB SRAM
// - No external strobes on internal accesses
// - Shared mode: SRAM fetched and written
// - No extended stack in shared mode
// - Reset: A19-16 high pins, PROGRAM_CHIP_ENABLES low
// - Upper field selects address lines
// - Chip enable field selects enables
// - Four equal program blocks per chip enable
// - Combine bits assert enable on data moves
// - Combined blocks: write strobe, store read
// - Internal data moves take 2 cycles
// - Stretch affects only external data moves
// - Stretch 0-7 gives 2..5,9..12 cycles
// - Reset stretch is one cycle
// - Stretch 1 adds setup and hold clock
// - Stretch 4+: longer latch, hold, strobes
// - Above 4 only strobe width grows
// - Strobe width scales with clock mode
// - Multiplier bit selects 2 or 1 clocks
// - Stack mode bit cleared by reset
module memmap_stretch (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Core access request
  input wire logic acc_req_i,
  input wire logic acc_code_i,
  input wire logic acc_write_i,
  input wire logic acc_stack_i,
  input wire logic [23:0] acc_addr_i,
  output logic acc_busy_o,
  output logic acc_done_o,
  // Internal memory selects
  output logic sram_sel_o,
  output logic can_sel_o,
  // External bus
  output logic [3:0] port4_fn_o,
  output logic [3:0] port4_upper_o,
  output logic [3:0] port4_upper_oe_o,
  output logic [3:0] port4_ce_n_o,
  output logic [3:0] port4_ce_oe_o,
  output logic [3:0] data_ce_n_o,
  output logic addr_latch_o,
  output logic write_n_o,
  output logic read_n_o,
  output logic program_store_strobe_n_o,
  output logic data_drive_o
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] port4_function_control; // Upper-address and chip-enable fields
  logic [7:0] memory_control; // SRAM map, CAN area, combine bits
  logic [7:0] address_control; // Stack mode bit
  logic [2:0] stretch_select; // Stretch field of clock control
  logic multiplier_factor; // 0: 2X, 1: 4X
  logic [1:0] clk_div; // Clock divide select
  logic shared_mode; // SRAM as program and data; driven by the decoding below

  // Port 4 control register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      port4_function_control <= memmap_pkg::PORT4_RESET;
    end else if (reg_wr_i && reg_addr_i == memmap_pkg::ADDR_PORT4_CTRL) begin
      port4_function_control <= {2'h0, reg_wdata_i[5:0]};
    end
  end

  // Memory control register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      memory_control <= memmap_pkg::MEM_RESET;
    end else if (reg_wr_i && reg_addr_i == memmap_pkg::ADDR_MEM_CTRL) begin
      memory_control <= {reg_wdata_i[7:5], 1'b0, reg_wdata_i[3:0]};
    end
  end

  // Address control: stack mode refused while SRAM is shared
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      address_control <= 8'h00;
    end else if (reg_wr_i && reg_addr_i == memmap_pkg::ADDR_ADDR_CTRL) begin
      address_control <= 8'h00;
      address_control[memmap_pkg::STACK_BIT] <=
        reg_wdata_i[memmap_pkg::STACK_BIT] && !shared_mode;
    end else if (shared_mode) begin
      address_control[memmap_pkg::STACK_BIT] <= 1'b0;
    end
  end

  // Clock control: stretch field; software may change it any time
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      stretch_select <= memmap_pkg::STRETCH_RESET;
      multiplier_factor <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == memmap_pkg::ADDR_CLK_CTRL) begin
      stretch_select <= reg_wdata_i[2:0];
    end else if (reg_wr_i && reg_addr_i == memmap_pkg::ADDR_CLK_MODE) begin
      multiplier_factor <= reg_wdata_i[memmap_pkg::MULT_BIT];
    end
  end

  // Clock divide select; must pass through divide-by-4 state
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_div <= memmap_pkg::CLKDIV_RESET;
    end else if (reg_wr_i && reg_addr_i == memmap_pkg::ADDR_CLK_MODE) begin
      if (clk_div == memmap_pkg::CLKDIV_RESET ||
        reg_wdata_i[1:0] == memmap_pkg::CLKDIV_RESET) begin
        if (reg_wdata_i[1:0] != 2'h1) begin
          clk_div <= reg_wdata_i[1:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoding
  logic [1:0] idm; // Internal memory config
  logic stack_mode; // Extended stack active
  logic [2:0] upper_field;
  logic [2:0] ce_field;
  assign idm = memory_control[memmap_pkg::IDM_LSB +: 2];
  assign shared_mode = (idm == 2'h3);
  assign stack_mode = address_control[memmap_pkg::STACK_BIT];
  assign upper_field = port4_function_control[memmap_pkg::UPPER_LSB +: 3];
  assign ce_field = port4_function_control[memmap_pkg::CE_LSB +: 3];

  // Mask of active lines for a 3-bit port 4 field (used twice)
  function automatic logic [3:0] field_mask(input logic [2:0] f);
    case (f)
      3'h4: field_mask = 4'h1;
      3'h5: field_mask = 4'h3;
      3'h6: field_mask = 4'h7;
      3'h7: field_mask = 4'hf;
      default: field_mask = 4'h0;
    endcase
  endfunction

  // SRAM hit: data map by config; stack uses lowest 1kB
  logic [23:0] sram_base;
  logic sram_hit;
  always_comb begin
    case (idm)
      2'h0: sram_base = memmap_pkg::SRAM_MID_BASE;
      2'h1: sram_base = memmap_pkg::SRAM_LOW_BASE;
      default: sram_base = memmap_pkg::SRAM_HIGH_BASE;
    endcase
    if (acc_stack_i) begin
      // Stack addresses index the bottom 1kB of the SRAM
      sram_hit = stack_mode && acc_addr_i[23:memmap_pkg::STACK_BITS] == 14'h0;
    end else if (acc_code_i) begin
      sram_hit = shared_mode && acc_addr_i[23:memmap_pkg::SRAM_BITS] ==
        sram_base[23:memmap_pkg::SRAM_BITS];
    end else begin
      // Data moves: lowest 1kB withheld while stack mode owns it
      sram_hit = acc_addr_i[23:memmap_pkg::SRAM_BITS] == sram_base[23:memmap_pkg::SRAM_BITS]
        && !(stack_mode && acc_addr_i[11:memmap_pkg::STACK_BITS] == 2'h0);
    end
  end

  // CAN message area hit
  logic can_hit;
  assign can_hit = !acc_code_i && !acc_stack_i &&
    acc_addr_i[23:memmap_pkg::CAN_BITS] ==
    (memory_control[memmap_pkg::CAN_SEL_BIT] ? memmap_pkg::CAN_HIGH_BASE[23:9] :
     memmap_pkg::CAN_LOW_BASE[23:9]);
  logic internal_hit;
  assign internal_hit = sram_hit || can_hit || acc_stack_i;

  // Chip-enable block: four equal blocks sized by upper field
  logic [1:0] block;
  always_comb begin
    case (upper_field)
      3'h4: block = acc_addr_i[18:17]; // 128kB
      3'h5: block = acc_addr_i[19:18]; // 256kB
      3'h6: block = acc_addr_i[20:19]; // 512kB
      3'h7: block = acc_addr_i[21:20]; // 1MB
      default: block = acc_addr_i[16:15]; // 32kB
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // External cycle sequencer
  memmap_pkg::bus_state_t state;
  // Sixteen bits: the longest power-management access runs to 49152 clocks
  logic [15:0] clk_cnt; // Clocks left in current phase
  logic [15:0] total_cnt; // Clocks left in the whole access
  logic [15:0] mc_clocks; // System clocks per machine cycle
  logic [15:0] next_phase;
  logic [15:0] hold_len; // Hold fills the access up to its full length
  logic [3:0] mc_total; // Machine cycles of the access
  logic [1:0] cur_block;
  logic cur_write;
  logic cur_code;
  logic cur_combined;
  logic slow;

  // Clocks per machine cycle from clock mode
  always_comb begin
    case (clk_div)
      2'h0: mc_clocks = multiplier_factor ? 16'h0001 : 16'h0002;
      // Power management: strobes 1024 times the divide-by-4 ones
      2'h3: mc_clocks = 16'h1000;
      default: mc_clocks = 16'h0004;
    endcase
  end

  // Machine cycles for an external data move
  always_comb begin
    mc_total = (stretch_select >= 3'h4) ? 4'(stretch_select) + 4'h5
      : 4'(stretch_select) + 4'h2;
  end
  assign slow = stretch_select >= 3'h4;

  // Whole-access clock budget; reloaded every idle cycle so a new stretch applies at once
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      total_cnt <= 16'h0;
    end else if (state == memmap_pkg::ST_IDLE) begin
      total_cnt <= 16'(mc_total * mc_clocks) - 16'h1;
    end else if (total_cnt != 16'h0) begin
      total_cnt <= total_cnt - 16'h1;
    end
  end

  // Hold takes what setup and strobe left; at one clock per machine cycle and stretch 0..3
  // setup and strobe use it all, so the access then runs a clock long
  assign hold_len = (cur_code || total_cnt == 16'h0) ? 16'h0 : total_cnt - 16'h1;

  // Phase lengths: setup, strobe, hold in machine-cycle clocks
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= memmap_pkg::ST_IDLE;
      clk_cnt <= 16'h0;
      cur_block <= 2'h0;
      cur_write <= 1'b0;
      cur_code <= 1'b0;
      cur_combined <= 1'b0;
    end else begin
      case (state)
        memmap_pkg::ST_IDLE: begin
          if (acc_req_i) begin
            cur_block <= block;
            cur_write <= acc_write_i;
            cur_code <= acc_code_i;
            cur_combined <= memory_control[block];
            state <= memmap_pkg::ST_SETUP;
            if (internal_hit) begin
              clk_cnt <= 16'(memmap_pkg::MC_INTERNAL * mc_clocks) - 16'h1;
              state <= memmap_pkg::ST_HOLD;
            end else if (acc_code_i) begin
              clk_cnt <= mc_clocks - 16'h1;
            end else begin
              // Setup: one clock at stretch 0, two at 1..3, extra MC at 4+
              clk_cnt <= slow ? mc_clocks + 16'h1 :
                (stretch_select == 3'h0 ? 16'h0 : 16'h1);
            end
          end
        end
        memmap_pkg::ST_SETUP: begin
          if (clk_cnt == 16'h0) begin
            state <= memmap_pkg::ST_STROBE;
            clk_cnt <= next_phase;
          end else begin
            clk_cnt <= clk_cnt - 16'h1;
          end
        end
        memmap_pkg::ST_STROBE: begin
          if (clk_cnt == 16'h0) begin
            state <= memmap_pkg::ST_HOLD;
            clk_cnt <= hold_len;
          end else begin
            clk_cnt <= clk_cnt - 16'h1;
          end
        end
        memmap_pkg::ST_HOLD: begin
          if (clk_cnt == 16'h0) begin
            state <= memmap_pkg::ST_IDLE;
          end else begin
            clk_cnt <= clk_cnt - 16'h1;
          end
        end
        default: state <= memmap_pkg::ST_IDLE;
      endcase
    end
  end

  // Strobe width: stretch x MC (stretch 0 gives half an MC), else leftover
  always_comb begin
    if (cur_code) begin
      next_phase = 16'h0;
    end else if (stretch_select == 3'h0) begin
      // Half a machine cycle; at one clock per cycle it rounds up to a clock
      next_phase = (mc_clocks > 16'h1) ? (mc_clocks >> 1) - 16'h1 : 16'h0;
    end else begin
      next_phase = 16'(stretch_select * mc_clocks) - 16'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  logic in_strobe;
  assign in_strobe = state == memmap_pkg::ST_STROBE;
  assign acc_busy_o = state != memmap_pkg::ST_IDLE;

  // Registered bus outputs
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_done_o <= 1'b0;
      addr_latch_o <= 1'b0;
      write_n_o <= 1'b1;
      read_n_o <= 1'b1;
      program_store_strobe_n_o <= 1'b1;
      data_drive_o <= 1'b0;
      sram_sel_o <= 1'b0;
      can_sel_o <= 1'b0;
      port4_upper_o <= 4'h0;
      port4_ce_n_o <= 4'he; // first fetch from 00000h with enable 0
      data_ce_n_o <= 4'hf;
    end else begin
      acc_done_o <= state == memmap_pkg::ST_HOLD && clk_cnt == 16'h0;
      addr_latch_o <= state == memmap_pkg::ST_SETUP;
      write_n_o <= !(in_strobe && cur_write && !cur_code);
      read_n_o <= !(in_strobe && !cur_write && !cur_code && !cur_combined);
      program_store_strobe_n_o <= !(in_strobe && !cur_write &&
        (cur_code || cur_combined));
      data_drive_o <= cur_write && (state == memmap_pkg::ST_STROBE ||
        (state == memmap_pkg::ST_HOLD && clk_cnt != 16'h0));
      if (acc_req_i && state == memmap_pkg::ST_IDLE) begin
        sram_sel_o <= sram_hit;
        can_sel_o <= can_hit;
        port4_upper_o <= acc_addr_i[19:16];
      end
      if (state == memmap_pkg::ST_IDLE) begin
        port4_ce_n_o <= 4'hf;
        data_ce_n_o <= 4'hf;
      end
      if (state == memmap_pkg::ST_SETUP) begin
        if (cur_code || cur_combined) begin
          port4_ce_n_o <= ~(4'h1 << cur_block);
        end else begin
          data_ce_n_o <= ~(4'h1 << cur_block);
        end
      end
    end
  end

  // Pin function of port 4: upper lines and chip enables
  assign port4_upper_oe_o = field_mask(upper_field);
  assign port4_ce_oe_o = field_mask(ce_field);
  assign port4_fn_o = {upper_field == 3'h7, ce_field == 3'h7, shared_mode, stack_mode};

  // Register read, one cycle later
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        memmap_pkg::ADDR_PORT4_CTRL: reg_rdata_o <= port4_function_control;
        memmap_pkg::ADDR_MEM_CTRL: reg_rdata_o <= memory_control;
        memmap_pkg::ADDR_ADDR_CTRL: reg_rdata_o <= address_control;
        memmap_pkg::ADDR_CLK_CTRL: reg_rdata_o <= {5'h0, stretch_select};
        memmap_pkg::ADDR_CLK_MODE: reg_rdata_o <= {5'h0, multiplier_factor, clk_div};
        memmap_pkg::ADDR_STATUS: reg_rdata_o <= {state, mc_total};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule // memmap_stretch

// >>> test/memmap_stretch_sva.sv
module memmap_stretch_sva (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // Access and bus
  input wire logic acc_req_i,
  input wire logic acc_busy_o,
  input wire logic sram_sel_o,
  input wire logic [3:0] port4_upper_oe_o,
  input wire logic [3:0] port4_ce_oe_o,
  input wire logic write_n_o,
  input wire logic read_n_o,
  input wire logic program_store_strobe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] p4; // Shadow of port4 control
  logic [2:0] str; // Shadow of stretch field
  logic [7:0] low; // Clocks with a data strobe low
  ////////////////////////////////////////
  // Pin mask selected by a 3-bit field
  function automatic logic [3:0] pmask(input logic [2:0] f);
    case (f)
      3'h4: return 4'h1;
      3'h5: return 4'h3;
      3'h6: return 4'h7;
      3'h7: return 4'hf;
      default: return 4'h0;
    endcase
  endfunction
  // Shadows follow register writes; divide mode assumed to stay at divide-by-4
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      p4 <= 8'h3f;
      str <= 3'h1;
    end else if (reg_wr_i && reg_addr_i == 8'h92) begin
      p4 <= {2'h0, reg_wdata_i[5:0]}; // Top two bits are not kept
    end else if (reg_wr_i && reg_addr_i == 8'h8e) begin
      str <= reg_wdata_i[2:0];
    end
  end
  // Width of the current data strobe in clocks
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      low <= 8'h00;
    end else if (!read_n_o || !write_n_o) begin
      low <= low + 8'h01;
    end else begin
      low <= 8'h00;
    end
  end
  a_int_no_strobe: assert property (@(posedge mclk_i) disable iff (rst_i)
    sram_sel_o && acc_busy_o |-> read_n_o && write_n_o && program_store_strobe_n_o)
    else $error("strobe during internal access");
  a_upper_pins: assert property (@(posedge mclk_i) disable iff (rst_i)
    p4[5] || p4[5:3] == 3'h0 |-> port4_upper_oe_o == pmask(p4[5:3]))
    else $error("upper address pin mask wrong");
  a_ce_pins: assert property (@(posedge mclk_i) disable iff (rst_i)
    p4[2] || p4[2:0] == 3'h0 |-> port4_ce_oe_o == pmask(p4[2:0]))
    else $error("chip enable pin mask wrong");
  a_strobe_width: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(read_n_o && write_n_o) |-> low == (str == 3'h0 ? 8'h02 : {3'h0, str, 2'h0}))
    else $error("data strobe width wrong");
  a_take_busy: assert property (@(posedge mclk_i) disable iff (rst_i)
    acc_req_i && !acc_busy_o |=> acc_busy_o [*4])
    else $error("access not held busy");
  a_one_strobe: assert property (@(posedge mclk_i) disable iff (rst_i)
    !(!read_n_o && !write_n_o))
    else $error("read and write strobes together");
  a_rdata_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read cycle");
  a_stretch_read: assert property (@(posedge mclk_i) disable iff (rst_i)
    $past(reg_rd_i) && $past(reg_addr_i) == 8'h8e |-> reg_rdata_o[2:0] == str)
    else $error("stretch field readback wrong");
  a_port4_read: assert property (@(posedge mclk_i) disable iff (rst_i)
    $past(reg_rd_i) && $past(reg_addr_i) == 8'h92 |-> reg_rdata_o == p4)
    else $error("port4 control readback wrong");
endmodule // memmap_stretch_sva

bind memmap_stretch memmap_stretch_sva chk (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .acc_req_i, .acc_busy_o, .sram_sel_o,
  .port4_upper_oe_o, .port4_ce_oe_o, .write_n_o, .read_n_o, .program_store_strobe_n_o);

// >>> test/ext_mem_model.sv
module ext_mem_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Strobes from the bus
  input wire logic read_n_i,
  input wire logic write_n_i,
  input wire logic store_n_i,
  // Cycles seen by the memory
  output logic [7:0] rd_cnt_o,
  output logic [7:0] wr_cnt_o,
  output logic [7:0] ps_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] last; // Strobes one clock ago
  // Each falling strobe is one memory cycle; glitches would count double
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      last <= 3'h7;
      rd_cnt_o <= 8'h00;
      wr_cnt_o <= 8'h00;
      ps_cnt_o <= 8'h00;
    end else begin
      last <= {read_n_i, write_n_i, store_n_i};
      if (last[2] && !read_n_i) rd_cnt_o <= rd_cnt_o + 8'h01;
      if (last[1] && !write_n_i) wr_cnt_o <= wr_cnt_o + 8'h01;
      if (last[0] && !store_n_i) ps_cnt_o <= ps_cnt_o + 8'h01;
    end
  end
endmodule // ext_mem_model

// >>> test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i, rst, wrs, rds, req, code, wrt, stk, sr, cn;
  logic [7:0] ra, wd, rdata, rdc, wrc, psc, dr, dw, dp, v;
  logic [23:0] addr, a;
  logic [3:0] upoe, ceoe, cen, ce, upo, dce, de;
  logic busy, done, ssel, csel, wrn, rdn, psn, alat;
  int failures, compares, lat, lat0, i, k, s, al;
  int le [8], li [8], lf [8];
  int mc [8] = '{2, 3, 4, 5, 9, 10, 11, 12}; // Machine cycles per stretch
  int sh [5] = '{15, 17, 18, 19, 20}; // Block size exponent per upper field
  logic [2:0] uf [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [23:0] tbl [5] = '{24'h00f000, 24'h000000, 24'h400000, 24'h00ee00, 24'h401000};
  ////////////////////////////////////////
  memmap_stretch dut (.mclk_i(mclk_i), .rst_i(rst), .reg_addr_i(ra), .reg_wdata_i(wd),
    .reg_wr_i(wrs), .reg_rd_i(rds), .reg_rdata_o(rdata), .acc_req_i(req), .acc_code_i(code),
    .acc_write_i(wrt), .acc_stack_i(stk), .acc_addr_i(addr), .acc_busy_o(busy),
    .acc_done_o(done), .sram_sel_o(ssel), .can_sel_o(csel), .port4_fn_o(),
    .port4_upper_o(upo), .port4_upper_oe_o(upoe), .port4_ce_n_o(cen), .port4_ce_oe_o(ceoe),
    .data_ce_n_o(dce), .addr_latch_o(alat), .write_n_o(wrn), .read_n_o(rdn),
    .program_store_strobe_n_o(psn), .data_drive_o());
  ext_mem_model mem (.mclk_i(mclk_i), .rst_i(rst), .read_n_i(rdn), .write_n_i(wrn),
    .store_n_i(psn), .rd_cnt_o(rdc), .wr_cnt_o(wrc), .ps_cnt_o(psc));
  // Free-running system clock
  initial begin
    mclk_i = 1'h0;
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge mclk_i);
    ra <= ad; wd <= d; wrs <= 1'h1;
    @(posedge mclk_i);
    wrs <= 1'h0;
  endtask
  // Read data only stand in the cycle after the strobe
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge mclk_i);
    ra <= ad; rds <= 1'h1;
    @(posedge mclk_i);
    rds <= 1'h0;
    #1 d = rdata;
  endtask
  // One access; selects and enables are only sampled while they mean something
  task automatic acc(input logic c, input logic w, input logic t, input logic [23:0] ad);
    logic [7:0] r0, w0, p0;
    r0 = rdc; w0 = wrc; p0 = psc;
    sr = 1'h0; cn = 1'h0; ce = 4'h0; de = 4'h0; lat = 0; al = 0;
    @(posedge mclk_i);
    code <= c; wrt <= w; stk <= t; addr <= ad; req <= 1'h1;
    @(posedge mclk_i);
    req <= 1'h0;
    #1;
    while (done !== 1'h1 && lat < 300) begin
      sr |= ssel & busy;
      cn |= csel & busy;
      if (!rdn || !wrn || !psn) ce |= ~cen;
      if (!rdn || !wrn) de |= ~dce;
      al += int'(alat); // Clocks with the address latch enable high
      @(posedge mclk_i);
      #1 lat++;
    end
    if (lat >= 300) begin
      failures++;
      print_verdict();
    end else begin
      dr = rdc - r0; dw = wrc - w0; dp = psc - p0;
    end
  endtask
  // Expected {can, sram} hit for an access
  function automatic logic [1:0] hit(input logic [2:0] m, input logic c, input logic [23:0] ad);
    logic [23:0] sb, cb;
    sb = m[2:1] == 2'h0 ? 24'h00f000 : m[2:1] == 2'h1 ? 24'h000000 : 24'h400000;
    cb = m[0] ? 24'h401000 : 24'h00ee00;
    hit[0] = ad[23:12] == sb[23:12] && (!c || m[2:1] == 2'h3);
    hit[1] = !c && ad[23:9] == cb[23:9];
  endfunction
  ////////////////////////////////////////
  initial begin
    rst = 1'h1; ra = 8'h00; wd = 8'h00; wrs = 1'h0; rds = 1'h0;
    req = 1'h0; code = 1'h0; wrt = 1'h0; stk = 1'h0; addr = 24'h000000;
    i = $urandom(80);
    repeat (12) @(posedge mclk_i);
    rst <= 1'h0;
    rd(8'h92, v); check("port4_rst", v, 8'h3f);
    rd(8'h8e, v); check("stretch_rst", v[2:0], 3'h1);
    rd(8'h9d, v); check("stack_rst", v[2], 1'h0);
    rd(8'h00, v); check("unmapped", v, 8'h00);
    check("pins_rst", {upoe, ceoe}, 8'hff);
    acc(1'h1, 1'h0, 1'h0, 24'h000000); check("first_fetch", {ce, dp}, 12'h101);
    acc(1'h0, 1'h0, 1'h0, 24'h100040); lat0 = lat;
    for (i = 0; i < 8; i++) begin
      wr(8'hc6, {i[2:0], 5'h00});
      for (k = 0; k < 10; k++) begin
        a = tbl[k / 2] | 24'($urandom % 512);
        acc(k[0], 1'h0, 1'h0, a);
        check("map", {cn, sr}, hit(i[2:0], k[0], a));
        if (hit(i[2:0], k[0], a) != 2'h0) check("no_strobe", dr | dp, 8'h00);
      end
    end
    wr(8'hc6, 8'h00);
    for (i = 0; i < 5; i++) begin
      wr(8'h92, {2'h0, uf[i], 3'h7});
      for (k = 0; k < 4; k++) begin
        a = 24'(k << sh[i]) | (24'($urandom) & ((24'h1 << sh[i]) - 24'h1));
        acc(1'h1, 1'h0, 1'h0, a);
        check("block", ce, 4'h1 << k);
        check("upper", upo, a[19:16]);
      end
    end
    wr(8'h92, 8'h3f);
    for (k = 1; k < 4; k++) begin
      a = 24'(k << 20) | 24'h010000 | 24'($urandom % 65536);
      wr(8'hc6, 8'h0f);
      acc(1'h0, 1'h1, 1'h0, a); check("comb_wr", {ce, dw, dr}, {4'h1 << k, 16'h0100});
      acc(1'h0, 1'h0, 1'h0, a); check("comb_rd", {dp, dr}, 16'h0100);
      wr(8'hc6, 8'h00);
      acc(1'h0, 1'h0, 1'h0, a); check("plain_rd", {ce, dr}, 12'h001);
      check("data_ce", de, 4'h1 << k);
    end
    for (s = 0; s < 8; s++) begin
      wr(8'h8e, 8'(s));
      acc(1'h0, 1'h0, 1'h0, 24'h100040); le[s] = lat;
      check("ale", al, s == 0 ? 1 : s < 4 ? 2 : 6);
      acc(1'h0, 1'h0, 1'h0, 24'h00f040); li[s] = lat;
      acc(1'h1, 1'h0, 1'h0, 24'h200040); lf[s] = lat;
      check("int_len", li[s], 2 * 4);
      check("fetch_len", lf[s], lf[0]);
      check("ext_len", le[s], 4 * mc[s]);
    end
    check("rst_len", le[1], lat0);
    wr(8'h9d, 8'h04); rd(8'h9d, v); check("stack_on", v[2], 1'h1);
    acc(1'h0, 1'h1, 1'h1, 24'h0003a5); check("stack_int", {sr, dw}, 9'h100);
    wr(8'h9d, 8'h00); wr(8'hc6, 8'hc0); wr(8'h9d, 8'h04);
    rd(8'h9d, v); check("stack_shared", v[2], 1'h0);
    wr(8'hc6, 8'h00);
    for (i = 0; i < 40; i++) begin
      s = $urandom % 8;
      wr(8'h8e, 8'(s));
      a = {4'h1, 20'($urandom)};
      k = $urandom % 2;
      acc(1'h0, k[0], 1'h0, a);
      check("strobes", k[0] ? dw : dr, 8'h01);
    end
    print_verdict();
  end
endmodule // tb_top
